// [src/nvram_host_pkg.sv]
// Purpose: constants and carrier types for the nonvolatile sram host controller
// Assumes: 20 MHz reference clock, 50 ns period
// Notes: timing counts derive from printed times; long counts become top parameters
package nvram_host_pkg;
   localparam int unsigned CLK_PERIOD_NS = 50;
   // -------------------------------------------------------------------------
   // device timing (slowest speed grade covered)
   // -------------------------------------------------------------------------
   localparam int unsigned CYCLE_TIME_NS = 45;          // least read/write cycle
   localparam int unsigned WRITE_PULSE_NS = 30;         // least write strobe width
   localparam int unsigned HW_SAVE_PULSE_WIDTH_NS = 15; // least low time of save pulse
   localparam int unsigned GRACE_TIME_NS = 25;          // pending cycle completion
   localparam int unsigned SAVE_TIME_MS = 8;
   localparam int unsigned RESTORE_TIME_US = 200;
   localparam int unsigned CMD_PROCESS_US = 100;
   localparam int unsigned POWER_UP_RESTORE_TIME_MS = 20;
   localparam int unsigned OUTPUT_ACTIVE_US = 5;        // save line high to outputs on
   // least times round up to whole cycles, never below one
   localparam int unsigned CYCLE_CLKS =
      (CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned HW_SAVE_PULSE_CLKS =
      (HW_SAVE_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned GRACE_CLKS =
      (GRACE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // waits on the device must cover its longest time; these divisions truncate, exact at 50 ns
   localparam int unsigned SAVE_CLKS = SAVE_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned RESTORE_CLKS = RESTORE_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int unsigned CMD_CLKS = CMD_PROCESS_US * 1000 / CLK_PERIOD_NS;
   localparam int unsigned POWER_UP_CLKS =
      POWER_UP_RESTORE_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned OUTPUT_ACTIVE_CLKS = OUTPUT_ACTIVE_US * 1000 / CLK_PERIOD_NS;
   localparam int unsigned WAIT_W = 24;
   localparam int unsigned SYNC_CLKS = 2;               // pin synchroniser depth in cycles
   // -------------------------------------------------------------------------
   // command sequence addresses, bits 14..2 significant
   // -------------------------------------------------------------------------
   localparam int unsigned ADDR_W = 17;
   localparam logic [15:0] SEQ_ADDR0 = 16'h4e38;
   localparam logic [15:0] SEQ_ADDR1 = 16'hb1c7;
   localparam logic [15:0] SEQ_ADDR2 = 16'h83e0;
   localparam logic [15:0] SEQ_ADDR3 = 16'h7c1f;
   localparam logic [15:0] SEQ_ADDR4 = 16'h703f;
   localparam logic [15:0] CMD_ADDR_SAVE = 16'h8fc0;
   localparam logic [15:0] CMD_ADDR_RESTORE = 16'h4c63;
   localparam logic [15:0] CMD_ADDR_AUTO_OFF = 16'h8b45;
   localparam logic [15:0] CMD_ADDR_AUTO_ON = 16'h4b46;

   typedef enum logic [2:0] {
      OP_READ, OP_WRITE, OP_SAVE, OP_RESTORE, OP_AUTO_OFF, OP_AUTO_ON, OP_HW_SAVE
   } op_t;

   // host request from user logic
   typedef struct packed {
      op_t op;
      logic [ADDR_W-1:0] addr;
      logic [15:0] wdata;
      logic [1:0] lane_en; // bit1 upper, bit0 lower, active high
   } host_req_t;

   // memory pins driven by the controller
   typedef struct packed {
      logic chip_sel_n;
      logic write_n;
      logic out_gate_n;
      logic upper_lane_enable_n;
      logic lower_lane_enable_n;
      logic [ADDR_W-1:0] addr;
   } mem_ctrl_t;
endpackage

// [src/nvram_host_ctrl.sv]
// Purpose: host controller driving an asynchronous nonvolatile sram port
// Assumes: single 20 MHz clock, synchronous active-high reset
// Notes: one request at a time; lockout waits are counted, then held until the save line reads high
module nvram_host_ctrl
   import nvram_host_pkg::*;
#(
   parameter int unsigned SAVE_WAIT = SAVE_CLKS,
   parameter int unsigned RESTORE_WAIT = RESTORE_CLKS,
   parameter int unsigned CMD_WAIT = CMD_CLKS,
   parameter int unsigned POWER_UP_WAIT = POWER_UP_CLKS,
   parameter int unsigned OUT_ACTIVE_WAIT = OUTPUT_ACTIVE_CLKS
) (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic req_valid_i,
   input wire host_req_t req_i,
   output logic req_ready_o,
   output logic rdata_valid_o,
   output logic [15:0] rdata_o,
   output mem_ctrl_t mem_o,
   output logic [15:0] dq_o,
   output logic [15:0] dq_oe_o,
   input wire logic [15:0] dq_i,
   output logic save_busy_line_n_o,
   output logic save_busy_line_n_oe_o,
   input wire logic save_busy_line_n_i
);
   // elaboration check: waits nonzero, power-up and save-plus-command loads fit the wait counter
   if (SAVE_WAIT < 1 || RESTORE_WAIT < 1 || CMD_WAIT < 1 || POWER_UP_WAIT < 1 ||
       OUT_ACTIVE_WAIT < 1 || POWER_UP_WAIT >= (1 << WAIT_W) ||
       SAVE_WAIT + CMD_WAIT >= (1 << WAIT_W)) begin : g_bad_wait
      $error("nvram_host_ctrl: wait parameter out of range");
   end
   typedef enum {S_POWER_UP, S_IDLE, S_ACCESS, S_GAP, S_HW_PULSE, S_HW_RISE, S_LOCKOUT}
      state_t;
   // full 16-bit command address mapped onto the word address bus
   function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] idx, input op_t op);
      logic [15:0] a;
      unique case (idx)
         3'h0: a = SEQ_ADDR0;
         3'h1: a = SEQ_ADDR1;
         3'h2: a = SEQ_ADDR2;
         3'h3: a = SEQ_ADDR3;
         3'h4: a = SEQ_ADDR4;
         default: begin
            if (op == OP_SAVE) a = CMD_ADDR_SAVE;
            else if (op == OP_RESTORE) a = CMD_ADDR_RESTORE;
            else if (op == OP_AUTO_OFF) a = CMD_ADDR_AUTO_OFF;
            else a = CMD_ADDR_AUTO_ON;
         end
      endcase
      return {1'b0, a};
   endfunction

   // -------------------------------------------------------------------------
   // pin synchronisers
   // -------------------------------------------------------------------------
   logic [15:0] dq_meta, dq_sync;
   logic busy_meta, busy_sync;
   always_ff @(posedge ref_clk_i) begin
      dq_meta <= dq_i;
      dq_sync <= dq_meta;
      busy_meta <= save_busy_line_n_i;
      busy_sync <= busy_meta;
   end

   // -------------------------------------------------------------------------
   // sequencer
   // -------------------------------------------------------------------------
   state_t state, next_state;
   logic [WAIT_W-1:0] cnt, next_cnt;
   logic [2:0] step, next_step;
   host_req_t cur, next_cur;
   mem_ctrl_t next_mem;
   logic [15:0] next_dq, next_dq_oe, next_rdata;
   logic next_ready, next_rvalid, next_busy_n, next_busy_oe;

   // one combinational block computes all next values of the sequencer
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_step = step;
      next_cur = cur;
      next_mem = mem_o;
      next_dq = dq_o;
      next_dq_oe = dq_oe_o;
      next_ready = 1'b0;
      next_rvalid = 1'b0;
      next_rdata = rdata_o;
      next_busy_n = 1'b1;
      next_busy_oe = 1'b0;
      unique case (state)
         S_POWER_UP: begin
            // power-up wait
            // the restore after supply rise is not observable, so wait it out
            if (cnt >= WAIT_W'(POWER_UP_WAIT - 1)) begin
               next_state = S_IDLE;
               next_ready = 1'b1;
               next_cnt = '0;
            end else begin
               next_cnt = cnt + 1'b1;
            end
         end
         S_IDLE: begin
            next_ready = 1'b1;
            if (req_valid_i && req_ready_o) begin
               next_ready = 1'b0;
               next_cur = req_i;
               next_cnt = '0;
               next_step = '0;
               if (req_i.op == OP_HW_SAVE) begin
                  next_state = S_HW_PULSE;
                  next_busy_n = 1'b0;
                  next_busy_oe = 1'b1;
               end else begin
                  next_state = S_ACCESS;
                  next_mem.chip_sel_n = 1'b0;
                  next_mem.write_n = (req_i.op != OP_WRITE);
                  next_mem.out_gate_n = (req_i.op != OP_READ);
                  next_mem.upper_lane_enable_n = ~req_i.lane_en[1];
                  next_mem.lower_lane_enable_n = ~req_i.lane_en[0];
                  if (req_i.op == OP_READ || req_i.op == OP_WRITE)
                     next_mem.addr = req_i.addr;
                  else
                     next_mem.addr = seq_addr(3'h0, req_i.op);
                  next_dq = req_i.wdata;
                  next_dq_oe = '0;
                  if (req_i.op == OP_WRITE)
                     next_dq_oe = {{8{req_i.lane_en[1]}}, {8{req_i.lane_en[0]}}};
               end
            end
         end
         S_ACCESS: begin
            // cycle time held
            // data reaches dq_sync two flops late, so stay selected until it is fresh
            if (cnt >= WAIT_W'(CYCLE_CLKS + SYNC_CLKS - 1)) begin
               next_mem.chip_sel_n = 1'b1;
               next_mem.write_n = 1'b1;
               next_mem.out_gate_n = 1'b1;
               next_dq_oe = '0;
               next_cnt = '0;
               next_state = S_GAP;
               if (cur.op == OP_READ) begin
                  next_rdata = dq_sync;
                  next_rvalid = 1'b1;
               end
            end else begin
               next_cnt = cnt + 1'b1;
            end
         end
         S_GAP: begin
            // one deselected cycle frames each step of a sequence
            next_cnt = '0;
            if (cur.op == OP_READ || cur.op == OP_WRITE) begin
               next_state = S_IDLE;
               next_ready = 1'b1;
            end else if (step == 3'h5) begin
               next_state = S_LOCKOUT;
               if (cur.op == OP_SAVE) next_cnt = WAIT_W'(CMD_WAIT + SAVE_WAIT);
               else if (cur.op == OP_RESTORE) next_cnt = WAIT_W'(CMD_WAIT + RESTORE_WAIT);
               else next_cnt = WAIT_W'(CMD_WAIT);
            end else begin
               next_step = step + 1'b1;
               next_state = S_ACCESS;
               next_mem.chip_sel_n = 1'b0;
               next_mem.addr = seq_addr(3'(step + 3'h1), cur.op);
            end
         end
         S_HW_PULSE: begin
            // pulse held one cycle, well over the least width
            if (cnt >= WAIT_W'(HW_SAVE_PULSE_CLKS - 1)) begin
               next_state = S_HW_RISE;
               next_cnt = '0;
            end else begin
               next_cnt = cnt + 1'b1;
               next_busy_n = 1'b0;
               next_busy_oe = 1'b1;
            end
         end
         S_HW_RISE: begin
            // wait for the device to release the line, then outputs settle
            // busy_sync lags the pin, so its first views still show the line before the pulse
            if (cnt < WAIT_W'(SYNC_CLKS)) begin
               next_cnt = cnt + 1'b1;
            end else if (busy_sync) begin
               next_state = S_LOCKOUT;
               next_cnt = WAIT_W'(OUT_ACTIVE_WAIT);
            end
         end
         S_LOCKOUT: begin
            if (cnt <= WAIT_W'(1) && busy_sync) begin
               next_state = S_IDLE;
               next_ready = 1'b1;
               next_cnt = '0;
            end else if (cnt > WAIT_W'(1)) begin
               next_cnt = cnt - 1'b1;
            end
         end
      endcase
   end

   // registers only; outputs come straight from these flops
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         state <= S_POWER_UP;
         cnt <= '0;
         step <= '0;
         cur <= '0;
         mem_o <= '{chip_sel_n: 1'b1, write_n: 1'b1, out_gate_n: 1'b1,
                    upper_lane_enable_n: 1'b1, lower_lane_enable_n: 1'b1, addr: '0};
         dq_o <= '0;
         dq_oe_o <= '0;
         req_ready_o <= 1'b0;
         rdata_valid_o <= 1'b0;
         rdata_o <= '0;
         save_busy_line_n_o <= 1'b1;
         save_busy_line_n_oe_o <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         step <= next_step;
         cur <= next_cur;
         mem_o <= next_mem;
         dq_o <= next_dq;
         dq_oe_o <= next_dq_oe;
         req_ready_o <= next_ready;
         rdata_valid_o <= next_rvalid;
         rdata_o <= next_rdata;
         save_busy_line_n_o <= next_busy_n;
         save_busy_line_n_oe_o <= next_busy_oe;
      end
   end

   // -------------------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);

   a_read_strobe_high: assert property (!mem_o.out_gate_n |-> mem_o.write_n)
      else $error("write strobe low while output gate active");
   a_save_line_idle: assert property (!mem_o.chip_sel_n |-> !save_busy_line_n_oe_o)
      else $error("save line driven during access");
   a_cmd_strobe_high: assert property ((state == S_ACCESS && cur.op inside
      {OP_SAVE, OP_RESTORE, OP_AUTO_OFF, OP_AUTO_ON}) |-> mem_o.write_n)
      else $error("write strobe low in command sequence");
   a_cycle_length: assert property ($fell(mem_o.chip_sel_n) |->
      !mem_o.chip_sel_n [*2])
      else $error("access shorter than cycle time");
   a_lockout_quiet: assert property (state == S_LOCKOUT |-> mem_o.chip_sel_n)
      else $error("access during lockout");
   a_powerup_quiet: assert property (state == S_POWER_UP |->
      mem_o.chip_sel_n && !req_ready_o)
      else $error("access during power-up restore");
   a_pulse_width: assert property ($rose(save_busy_line_n_oe_o) |->
      !save_busy_line_n_o [*1])
      else $error("save pulse too short");
   a_seq_first: assert property ((state == S_IDLE && next_state == S_ACCESS &&
      req_i.op == OP_SAVE) |=> mem_o.addr == {1'b0, SEQ_ADDR0})
      else $error("command sequence does not start at first address");
   a_write_no_oe: assert property (!mem_o.write_n |->
      mem_o.out_gate_n && !mem_o.chip_sel_n)
      else $error("write strobe outside a select or with output gate active");
   c_read: cover property (rdata_valid_o);
   c_save_cmd: cover property (state == S_LOCKOUT && cur.op == OP_SAVE);
   c_hw_save: cover property (state == S_HW_RISE ##1 state == S_LOCKOUT);
   c_write: cover property (!mem_o.write_n);
endmodule // nvram_host_ctrl

// [test/nvram_dev_model.sv]
// Purpose: behavioural model of the nonvolatile sram facing the host controller
// Assumes: sampled on the controller clock; times are short parameters
// Notes: undriven data lines are resolved by the bench, not here
module nvram_dev_model
   import nvram_host_pkg::*;
#(
   parameter int unsigned PU_TIME = 8,
   parameter int unsigned CMD_TIME = 3,
   parameter int unsigned SAVE_TIME = 30,
   parameter int unsigned RESTORE_TIME = 12,
   parameter int unsigned HIGH_TIME = 2
) (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire mem_ctrl_t mem_i,
   input wire logic [15:0] dq_i,
   input wire logic hw_req_i,
   input wire logic line_i,
   output logic [15:0] dq_o,
   output logic [15:0] dq_oe_o,
   output logic save_drv_o,
   output logic save_lvl_o,
   output logic [15:0] last_cmd_o,
   output logic [7:0] err_o
);
   logic [15:0] mem [256];
   logic [15:0] nv [256];
   logic [7:0] busy, high;
   logic [2:0] step;
   logic [1:0] kind;
   logic pending, cs_q, we_sel_q, we_sel, rd;
   logic [12:0] seq [6];
   initial foreach (nv[i]) nv[i] = 16'h0000;
   assign seq = '{SEQ_ADDR0[14:2], SEQ_ADDR1[14:2], SEQ_ADDR2[14:2], SEQ_ADDR3[14:2],
                  SEQ_ADDR4[14:2], 13'h0000};
   assign we_sel = cs_q ? !mem_i.write_n : we_sel_q;
   assign rd = !mem_i.chip_sel_n && !mem_i.out_gate_n && mem_i.write_n && !we_sel && busy == 0;
   assign dq_oe_o = {{8{rd && !mem_i.upper_lane_enable_n}}, {8{rd && !mem_i.lower_lane_enable_n}}};
   assign dq_o = mem[mem_i.addr[7:0]];
   // drive high briefly, then release to pull-up
   assign save_drv_o = busy != 0 || high != 0;
   assign save_lvl_o = busy == 0;
   // ------------------------------------------------------------------
   // sequencing
   // ------------------------------------------------------------------
   always @(posedge ref_clk_i) begin
      cs_q <= mem_i.chip_sel_n;
      if (cs_q) we_sel_q <= !mem_i.write_n;
      if (reset_i) begin
         busy <= 8'(PU_TIME);
         kind <= 2'd2;
         high <= 8'h00;
         step <= 3'd0;
         pending <= 1'b0;
         err_o <= 8'h00;
         last_cmd_o <= 16'h0000;
      end else if (busy != 0) begin
         busy <= busy - 8'h01;
         if (busy == 8'h01) begin
            if (kind == 2'd2) mem <= nv;
            if (kind != 2'd0) pending <= 1'b0;
            high <= 8'(HIGH_TIME);
         end
      end else begin
         if (high != 0) high <= high - 8'h01;
         // save line must be high during accesses
         if (!mem_i.chip_sel_n && !line_i) err_o <= err_o + 8'h01;
         // grace: a write sampled on a trigger edge still lands, busy starts after it
         if (!mem_i.chip_sel_n && !mem_i.write_n) begin
            if (!mem_i.upper_lane_enable_n) mem[mem_i.addr[7:0]][15:8] <= dq_i[15:8];
            if (!mem_i.lower_lane_enable_n) mem[mem_i.addr[7:0]][7:0] <= dq_i[7:0];
            pending <= 1'b1;
            step <= 3'd0;
         end else if (cs_q && !mem_i.chip_sel_n) begin
            step <= (mem_i.addr[14:2] == seq[0]) ? 3'd1 : 3'd0;
            if (step < 5 && mem_i.addr[14:2] == seq[step]) step <= step + 3'd1;
            if (step == 5) begin
               last_cmd_o <= mem_i.addr[15:0];
               kind <= 2'd0;
               busy <= 8'(CMD_TIME);
               if (mem_i.addr[14:2] == CMD_ADDR_SAVE[14:2]) begin
                  nv <= mem;
                  kind <= 2'd1;
                  busy <= 8'(CMD_TIME + SAVE_TIME);
               end
               if (mem_i.addr[14:2] == CMD_ADDR_RESTORE[14:2]) begin
                  kind <= 2'd2;
                  busy <= 8'(CMD_TIME + RESTORE_TIME);
               end
            end
         end
         // save only with a pending write
         if (hw_req_i && pending) begin
            nv <= mem;
            kind <= 2'd1;
            busy <= 8'(SAVE_TIME);
         end
      end
   end
endmodule // nvram_dev_model

// [test/tb_top.sv]
// Purpose: self-checking bench for the nonvolatile sram host controller
// Assumes: device model on the far side, pull-up on the save line
// Notes: read results are queued by the driver and checked by a monitor
module tb_top
   import nvram_host_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned CMDT = 3;
   localparam int unsigned SAVT = 30;
   localparam int unsigned RSTT = 12;
   localparam int unsigned PUWT = 10;
   logic ref_clk_i = 0, reset_i = 1, req_valid_i = 0, req_ready_o, rdata_valid_o;
   host_req_t req_i = '0;
   mem_ctrl_t mem_o;
   logic [15:0] rdata_o, c_dq, c_oe, m_dq, m_oe, dq_wire, last_cmd;
   logic [15:0] dq_last = 16'h0000;
   logic c_so, c_soe, m_drv, m_lvl, line;
   logic [7:0] err;
   logic [15:0] shadow [256];
   logic [15:0] shadow_nv [256];
   logic [31:0] exp_q [$];
   int fails = 0, comparisons = 0;
   always #25 ref_clk_i = ~ref_clk_i;
   // undriven data lines show the inverse of their last level
   assign dq_wire = (m_oe & m_dq) | (~m_oe & c_oe & c_dq) | (~m_oe & ~c_oe & ~dq_last);
   assign line = ~((c_soe & ~c_so) | (m_drv & ~m_lvl));
   always @(posedge ref_clk_i) dq_last <= dq_wire;
   nvram_host_ctrl #(.SAVE_WAIT(20), .RESTORE_WAIT(10), .CMD_WAIT(5), .POWER_UP_WAIT(PUWT),
      .OUT_ACTIVE_WAIT(4)) dut_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
      .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
      .rdata_valid_o(rdata_valid_o), .rdata_o(rdata_o), .mem_o(mem_o), .dq_o(c_dq),
      .dq_oe_o(c_oe), .dq_i(dq_wire), .save_busy_line_n_o(c_so),
      .save_busy_line_n_oe_o(c_soe), .save_busy_line_n_i(line));
   nvram_dev_model #(.CMD_TIME(CMDT), .SAVE_TIME(SAVT), .RESTORE_TIME(RSTT)) model_u (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i), .mem_i(mem_o), .dq_i(dq_wire),
      .hw_req_i(c_soe & ~c_so), .line_i(line), .dq_o(m_dq), .dq_oe_o(m_oe),
      .save_drv_o(m_drv), .save_lvl_o(m_lvl), .last_cmd_o(last_cmd), .err_o(err));
   // ------------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // one request; cyc counts cycles from the take until ready returns
   task automatic do_req(input op_t op, input logic [16:0] a, input logic [15:0] d,
                         input logic [1:0] ln, output int cyc);
      cyc = 0;
      while (req_ready_o !== 1'b1) begin
         @(posedge ref_clk_i);
         #2;
      end
      req_valid_i = 1'b1;
      req_i = '{op: op, addr: a, wdata: d, lane_en: ln};
      @(posedge ref_clk_i);
      #2;
      req_valid_i = 1'b0;
      while (req_ready_o !== 1'b1 && cyc < 2000) begin
         @(posedge ref_clk_i);
         #2;
         cyc++;
      end
      if (cyc >= 2000) begin
         fails++;
         report_and_stop();
      end
   endtask
   // read monitor: oldest note against each returned word
   always @(negedge ref_clk_i) begin
      logic [31:0] e;
      if (rdata_valid_o === 1'b1) begin
         if (exp_q.size() == 0) check("unexpected read", 16'h0001, 16'h0000);
         else begin
            e = exp_q.pop_front();
            check("read data", rdata_o & e[31:16], e[15:0] & e[31:16]);
         end
      end
   end
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      fails++;
      report_and_stop();
   end
   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      int cyc;
      logic [16:0] a;
      logic [15:0] d;
      logic [1:0] ln;
      void'($urandom(16666));
      foreach (shadow[i]) shadow[i] = 16'h0000;
      repeat (12) @(posedge ref_clk_i);
      #2;
      reset_i = 1'b0;
      cyc = 0;
      while (req_ready_o !== 1'b1 && cyc < 100) begin
         @(posedge ref_clk_i);
         #2;
         cyc++;
      end
      check("power-up wait", 16'(cyc >= PUWT), 16'h0001);
      $display("test power-up done");
      for (int i = 0; i < 12; i++) begin
         a = 17'($urandom_range(255));
         d = 16'($urandom);
         ln = 2'($urandom_range(3));
         do_req(OP_WRITE, a, d, ln, cyc);
         if (ln[1]) shadow[a[7:0]][15:8] = d[15:8];
         if (ln[0]) shadow[a[7:0]][7:0] = d[7:0];
         ln = 2'($urandom_range(3));
         exp_q.push_back({{8{ln[1]}}, {8{ln[0]}}, shadow[a[7:0]]});
         do_req(OP_READ, a, 16'h0000, ln, cyc);
      end
      $display("test lanes done");
      do_req(OP_WRITE, 17'h00005, 16'ha5c3, 2'b11, cyc);
      shadow[5] = 16'ha5c3;
      shadow_nv = shadow;
      do_req(OP_SAVE, 17'h00000, 16'h0000, 2'b00, cyc);
      check("save lockout", 16'(cyc >= 21 + CMDT + SAVT), 16'h0001);
      check("save code", last_cmd, CMD_ADDR_SAVE);
      do_req(OP_WRITE, 17'h00005, 16'h1e2d, 2'b11, cyc);
      do_req(OP_RESTORE, 17'h00000, 16'h0000, 2'b00, cyc);
      check("restore lockout", 16'(cyc >= 21 + CMDT + RSTT), 16'h0001);
      check("restore code", last_cmd, CMD_ADDR_RESTORE);
      shadow = shadow_nv;
      exp_q.push_back({16'hffff, shadow[5]});
      do_req(OP_READ, 17'h00005, 16'h0000, 2'b11, cyc);
      $display("test save restore done");
      for (int k = 0; k < 2; k++) begin
         do_req(k == 0 ? OP_AUTO_OFF : OP_AUTO_ON, 17'h00000, 16'h0000, 2'b00, cyc);
         check("auto code", last_cmd, k == 0 ? CMD_ADDR_AUTO_OFF : CMD_ADDR_AUTO_ON);
      end
      $display("test auto mode done");
      do_req(OP_HW_SAVE, 17'h00000, 16'h0000, 2'b00, cyc);
      check("hw save skipped", 16'(cyc < SAVT), 16'h0001);
      do_req(OP_WRITE, 17'h00009, 16'h3c3c, 2'b11, cyc);
      do_req(OP_HW_SAVE, 17'h00000, 16'h0000, 2'b00, cyc);
      check("hw save lockout", 16'(cyc >= 2 + SAVT + 4), 16'h0001);
      check("line during access", {8'h00, err}, 16'h0000);
      check("reads pending", 16'(exp_q.size()), 16'h0000);
      $display("test hardware save done");
      report_and_stop();
   end
endmodule // tb_top
